// ---- hw/fcm_pkg.sv ----
package fcm_pkg;

    // instruction field positions
    localparam int FLD_TOP_LSB = 12;
    localparam int FLD_N_LSB = 8;
    localparam int FLD_M_LSB = 4;
    localparam int FLD_SUB_LSB = 0;

    // top nibble shared by every operation of this slice
    localparam logic [3:0] OPC_TOP = 4'hF;

    // low nibble codes
    localparam logic [3:0] SUB_IDX_LOAD = 4'h6;
    localparam logic [3:0] SUB_IDX_STORE = 4'h7;
    localparam logic [3:0] SUB_LOAD = 4'h8;
    localparam logic [3:0] SUB_POSTINC_LOAD = 4'h9;
    localparam logic [3:0] SUB_STORE = 4'hA;
    localparam logic [3:0] SUB_PREDEC_STORE = 4'hB;
    localparam logic [3:0] SUB_REG_MOVE = 4'hC;
    localparam logic [3:0] SUB_SYS = 4'hD;
    localparam logic [3:0] SUB_MAC = 4'hE;

    // second nibble codes under SUB_SYS
    localparam logic [3:0] SYS_COMM_TO_FR = 4'h0;
    localparam logic [3:0] SYS_FR_TO_COMM = 4'h1;
    localparam logic [3:0] SYS_INT_CONVERT = 4'h2;

    // timing of the register-to-register operations, in cycles
    localparam int OP_LATENCY = 2;
    localparam int OP_ISSUE = 1;

    localparam int FR_COUNT = 16;
    localparam logic [31:0] FR_RST = 32'h00000000;
    localparam logic [31:0] COMM_RST = 32'h00000000;
    localparam logic [31:0] GP_STEP = 32'h00000004;

    // single precision layout
    localparam int EXP_LSB = 23;
    localparam int QNAN_BIT = 22;
    localparam logic [7:0] EXP_MAX = 8'hFF;
    localparam logic [31:0] DEFAULT_QNAN = 32'h7FFFFFFF;

    // internal exponent offsets of the 51-bit normaliser
    localparam logic signed [11:0] EXP_INT_CONV = 12'sh09D;
    localparam logic signed [11:0] EXP_MUL_BIAS = 12'sh07E;

    typedef enum logic [1:0] {
        FCM_IDLE = 2'b01,
        FCM_MEM = 2'b10
    } fcm_state_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } fcm_mem_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] sel;
        logic [31:0] data;
    } fcm_gp_wb_t;

endpackage

// ---- hw/fcm_fpu_slice.sv ----
`timescale 1ns/1ns

// Contract
// - the integer-convert operation reads the comm register as a signed integer and writes its single-precision value to the destination FP register, latency 2, issue 1.
// - the multiply-accumulate operation multiplies FP register zero by the source FP register, latency 2, issue 1.
// - the multiply-accumulate operation adds the destination register's prior value and writes the sum back to that destination only.
// - a denormal multiply-accumulate operand behaves as a zero of the same sign.
// - the two comm moves copy 32 bits unchanged between an FP register and the comm register.
// - the post-increment load adds 4 to the general register only when the load has no address error.
// - the pre-decrement store writes at base minus 4 and updates the base only when the store succeeds.
// - the indexed moves address memory at the index register plus the base register in both directions.
module fcm_fpu_slice (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic [15:0] op_code,
    input wire logic [31:0] gp_source_val,
    input wire logic [31:0] gp_dest_val,
    input wire logic [31:0] gp_index_val,
    input wire logic comm_wr_valid,
    input wire logic [31:0] comm_wr_data,
    input wire logic mem_done,
    input wire logic mem_addr_err,
    input wire logic [31:0] mem_rdata,
    input wire logic [3:0] fr_rd_sel,
    output logic op_ready,
    output fcm_pkg::fcm_mem_req_t mem_req,
    output fcm_pkg::fcm_gp_wb_t gp_wb,
    output logic [31:0] fp_comm_register,
    output logic [31:0] fr_rd_data,
    output logic invalid_evt,
    output logic addr_err_evt
);

    typedef struct packed {
        fcm_pkg::fcm_state_t state;
        logic ready;
        logic [fcm_pkg::FR_COUNT-1:0][31:0] fr;
        logic [31:0] comm;
        logic s1_fr_we;
        logic [3:0] s1_dst;
        logic [31:0] s1_res;
        logic s1_comm_we;
        logic m_load;
        logic [3:0] m_dst;
        fcm_pkg::fcm_gp_wb_t m_gp;
        fcm_pkg::fcm_mem_req_t mem;
        fcm_pkg::fcm_gp_wb_t gp;
        logic [31:0] rd_data;
        logic invalid;
        logic addr_err;
    } fcm_st_t;

    fcm_st_t s_r;
    fcm_st_t s_nxt;

    // normalise, round to nearest even, flush tiny results to zero
    function automatic logic [31:0] fp_pack(
        input logic s,
        input logic signed [11:0] e,
        input logic [50:0] m
    );
        logic [5:0] lz;
        logic found;
        logic [50:0] mn;
        logic signed [11:0] be;
        logic inc;
        logic [24:0] sig;
        logic [31:0] r;
        lz = '0;
        found = 1'b0;
        for (int i = 50; i >= 0; i--)
        begin
            if (!found)
            begin
                if (m[i])
                    found = 1'b1;
                else
                    lz = 6'(lz + 6'd1);
            end
        end
        mn = m << lz;
        be = e + 12'sd1 - $signed({6'b0, lz});
        inc = mn[26] & ((|mn[25:0]) | mn[27]);
        sig = {1'b0, mn[50:27]} + {24'b0, inc};
        if (sig[24])
            be = be + 12'sd1;
        if (m == '0)
            r = {s, 31'b0};
        else if (be >= $signed({4'b0, fcm_pkg::EXP_MAX}))
            r = {s, fcm_pkg::EXP_MAX, 23'b0};
        else if (be <= 12'sd0)
            r = {s, 31'b0};
        else
            r = {s, be[7:0], sig[22:0]};
        return r;
    endfunction

    function automatic logic is_zero(input logic [31:0] x);
        return x[30:fcm_pkg::EXP_LSB] == 8'h00;
    endfunction

    function automatic logic is_inf(input logic [31:0] x);
        return x[30:fcm_pkg::EXP_LSB] == fcm_pkg::EXP_MAX && x[22:0] == 23'h0;
    endfunction

    function automatic logic is_nan(input logic [31:0] x);
        return x[30:fcm_pkg::EXP_LSB] == fcm_pkg::EXP_MAX && x[22:0] != 23'h0;
    endfunction

    function automatic logic is_snan(input logic [31:0] x);
        return is_nan(x) && !x[fcm_pkg::QNAN_BIT];
    endfunction

    // returns {invalid, a * b + c}
    function automatic logic [32:0] fp_mac(
        input logic [31:0] a,
        input logic [31:0] b,
        input logic [31:0] c
    );
        logic ps;
        logic pinf;
        logic pzero;
        logic [47:0] p;
        logic [50:0] mp;
        logic [50:0] mc;
        logic [50:0] mx;
        logic [50:0] my;
        logic [50:0] sh;
        logic [50:0] sum;
        logic signed [11:0] ep;
        logic signed [11:0] ec;
        logic signed [11:0] eb;
        logic signed [11:0] d;
        logic [5:0] dd;
        logic sx;
        logic sy;
        logic so;
        logic [32:0] r;
        ps = a[31] ^ b[31];
        pinf = is_inf(a) | is_inf(b);
        pzero = is_zero(a) | is_zero(b);
        p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
        mp = {1'b0, p, 2'b0};
        ep = $signed({4'b0, a[30:23]}) + $signed({4'b0, b[30:23]}) - fcm_pkg::EXP_MUL_BIAS;
        mc = is_zero(c) ? '0 : {2'b01, c[22:0], 26'b0};
        ec = $signed({4'b0, c[30:23]});
        if (ep >= ec)
        begin
            eb = ep;
            d = ep - ec;
            mx = mp;
            sx = ps;
            my = mc;
            sy = c[31];
        end
        else
        begin
            eb = ec;
            d = ec - ep;
            mx = mc;
            sx = c[31];
            my = mp;
            sy = ps;
        end
        dd = (d > 12'sd50) ? 6'd51 : d[5:0];
        sh = my >> dd;
        sh[0] = sh[0] | (|(my & ((51'b1 << dd) - 51'b1)));
        if (sx == sy)
        begin
            sum = mx + sh;
            so = sx;
        end
        else if (mx >= sh)
        begin
            sum = mx - sh;
            so = sx;
        end
        else
        begin
            sum = sh - mx;
            so = sy;
        end
        if (sum == '0)
            so = 1'b0;
        if (is_snan(a) | is_snan(b) | is_snan(c))
            r = {1'b1, fcm_pkg::DEFAULT_QNAN};
        else if (is_nan(a) | is_nan(b) | is_nan(c))
            r = {1'b0, fcm_pkg::DEFAULT_QNAN};
        else if ((is_inf(a) & is_zero(b)) | (is_zero(a) & is_inf(b)))
            r = {1'b1, fcm_pkg::DEFAULT_QNAN};
        else if (pinf & is_inf(c) & (ps != c[31]))
            r = {1'b1, fcm_pkg::DEFAULT_QNAN};
        else if (pinf)
            r = {1'b0, ps, fcm_pkg::EXP_MAX, 23'b0};
        else if (is_inf(c))
            r = {1'b0, c};
        else if (pzero & is_zero(c))
            r = {1'b0, ps & c[31], 31'b0};
        else if (pzero)
            r = {1'b0, c};
        else
            r = {1'b0, fp_pack(so, eb, sum)};
        return r;
    endfunction

    function automatic logic [31:0] int_to_fp(input logic [31:0] v);
        logic [31:0] mag;
        mag = v[31] ? 32'(-v) : v;
        return fp_pack(v[31], fcm_pkg::EXP_INT_CONV, {mag, 19'b0});
    endfunction

    logic [3:0] f_n;
    logic [3:0] f_m;
    logic [3:0] f_sub;
    logic [31:0] rd_n;
    logic [31:0] rd_m;
    logic [31:0] rd_z;
    logic [31:0] rd_comm;
    logic [32:0] mac_out;
    logic take;

    assign f_n = op_code[fcm_pkg::FLD_N_LSB +: 4];
    assign f_m = op_code[fcm_pkg::FLD_M_LSB +: 4];
    assign f_sub = op_code[fcm_pkg::FLD_SUB_LSB +: 4];
    assign take = op_valid & s_r.ready & (op_code[fcm_pkg::FLD_TOP_LSB +: 4] == fcm_pkg::OPC_TOP);

    // bypass the result that is being written this cycle
    assign rd_n = (s_r.s1_fr_we && s_r.s1_dst == f_n) ? s_r.s1_res : s_r.fr[f_n];
    assign rd_m = (s_r.s1_fr_we && s_r.s1_dst == f_m) ? s_r.s1_res : s_r.fr[f_m];
    assign rd_z = (s_r.s1_fr_we && s_r.s1_dst == 4'h0) ? s_r.s1_res : s_r.fr[0];
    assign rd_comm = s_r.s1_comm_we ? s_r.s1_res : s_r.comm;
    assign mac_out = fp_mac(rd_z, rd_m, rd_n);

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.s1_fr_we = 1'b0;
        s_nxt.s1_comm_we = 1'b0;
        s_nxt.gp.valid = 1'b0;
        s_nxt.invalid = 1'b0;
        s_nxt.addr_err = 1'b0;
        if (s_r.s1_fr_we)
            s_nxt.fr[s_r.s1_dst] = s_r.s1_res;
        if (s_r.s1_comm_we)
            s_nxt.comm = s_r.s1_res;
        if (comm_wr_valid)
            s_nxt.comm = comm_wr_data;
        s_nxt.rd_data = s_nxt.fr[fr_rd_sel];
        s_nxt.s1_dst = f_n;
        s_nxt.m_dst = f_n;
        s_nxt.m_gp = '0;
        s_nxt.m_load = 1'b1;
        case (s_r.state)
            fcm_pkg::FCM_IDLE:
            begin
                if (take)
                begin
                    case (f_sub)
                        fcm_pkg::SUB_MAC:
                        begin
                            s_nxt.s1_fr_we = 1'b1;
                            s_nxt.s1_res = mac_out[31:0];
                            s_nxt.invalid = mac_out[32];
                        end
                        fcm_pkg::SUB_REG_MOVE:
                        begin
                            s_nxt.s1_fr_we = 1'b1;
                            s_nxt.s1_res = rd_m;
                        end
                        fcm_pkg::SUB_SYS:
                        begin
                            if (f_m == fcm_pkg::SYS_INT_CONVERT)
                            begin
                                s_nxt.s1_fr_we = 1'b1;
                                s_nxt.s1_res = int_to_fp(rd_comm);
                            end
                            else if (f_m == fcm_pkg::SYS_COMM_TO_FR)
                            begin
                                s_nxt.s1_fr_we = 1'b1;
                                s_nxt.s1_res = rd_comm;
                            end
                            else if (f_m == fcm_pkg::SYS_FR_TO_COMM)
                            begin
                                s_nxt.s1_comm_we = 1'b1;
                                s_nxt.s1_res = rd_n;
                            end
                        end
                        fcm_pkg::SUB_LOAD, fcm_pkg::SUB_POSTINC_LOAD, fcm_pkg::SUB_IDX_LOAD:
                        begin
                            s_nxt.state = fcm_pkg::FCM_MEM;
                            s_nxt.ready = 1'b0;
                            s_nxt.mem = '{valid: 1'b1, we: 1'b0, addr: gp_source_val, wdata: '0};
                            if (f_sub == fcm_pkg::SUB_IDX_LOAD)
                                s_nxt.mem.addr = gp_index_val + gp_source_val;
                            if (f_sub == fcm_pkg::SUB_POSTINC_LOAD)
                                s_nxt.m_gp = '{valid: 1'b1, sel: f_m,
                                    data: gp_source_val + fcm_pkg::GP_STEP};
                        end
                        fcm_pkg::SUB_STORE, fcm_pkg::SUB_PREDEC_STORE, fcm_pkg::SUB_IDX_STORE:
                        begin
                            s_nxt.state = fcm_pkg::FCM_MEM;
                            s_nxt.ready = 1'b0;
                            s_nxt.m_load = 1'b0;
                            s_nxt.mem = '{valid: 1'b1, we: 1'b1, addr: gp_dest_val, wdata: rd_m};
                            if (f_sub == fcm_pkg::SUB_IDX_STORE)
                                s_nxt.mem.addr = gp_index_val + gp_dest_val;
                            if (f_sub == fcm_pkg::SUB_PREDEC_STORE)
                            begin
                                s_nxt.mem.addr = gp_dest_val - fcm_pkg::GP_STEP;
                                s_nxt.m_gp = '{valid: 1'b1, sel: f_n,
                                    data: gp_dest_val - fcm_pkg::GP_STEP};
                            end
                        end
                        default:
                        begin
                            s_nxt.s1_fr_we = 1'b0;
                        end
                    endcase
                end
            end
            fcm_pkg::FCM_MEM:
            begin
                s_nxt.m_load = s_r.m_load;
                s_nxt.m_dst = s_r.m_dst;
                s_nxt.m_gp = s_r.m_gp;
                if (mem_done)
                begin
                    s_nxt.state = fcm_pkg::FCM_IDLE;
                    s_nxt.ready = 1'b1;
                    s_nxt.mem.valid = 1'b0;
                    if (mem_addr_err)
                        s_nxt.addr_err = 1'b1;
                    else
                    begin
                        s_nxt.gp = s_r.m_gp;
                        s_nxt.s1_fr_we = s_r.m_load;
                        s_nxt.s1_dst = s_r.m_dst;
                        s_nxt.s1_res = mem_rdata;
                    end
                end
            end
            default:
            begin
                s_nxt.state = fcm_pkg::FCM_IDLE;
                s_nxt.ready = 1'b1;
                s_nxt.mem.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.state <= fcm_pkg::FCM_IDLE;
            s_r.ready <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign op_ready = s_r.ready;
    assign mem_req = s_r.mem;
    assign gp_wb = s_r.gp;
    assign fp_comm_register = s_r.comm;
    assign fr_rd_data = s_r.rd_data;
    assign invalid_evt = s_r.invalid;
    assign addr_err_evt = s_r.addr_err;

endmodule

// ---- dv/fcm_fpu_slice_props.sv ----
`timescale 1ns/1ns
module fcm_fpu_slice_props (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic [15:0] op_code,
    input wire logic [31:0] gp_source_val,
    input wire logic [31:0] gp_dest_val,
    input wire logic [31:0] gp_index_val,
    input wire logic mem_done,
    input wire logic mem_addr_err,
    input wire logic op_ready,
    input fcm_pkg::fcm_mem_req_t mem_req,
    input fcm_pkg::fcm_gp_wb_t gp_wb,
    input wire logic invalid_evt,
    input wire logic addr_err_evt
);
    logic take;
    logic ok_done;
    logic [3:0] kind_r;
    assign take = op_valid && op_ready && op_code[15:12] == fcm_pkg::OPC_TOP;
    assign ok_done = mem_req.valid && mem_done && !mem_addr_err;
    // remembers which memory form is outstanding
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            kind_r <= 4'h0;
        else if (take)
            kind_r <= op_code[3:0];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_postinc_addr: assert property (take && op_code[3:0] == fcm_pkg::SUB_POSTINC_LOAD
        |=> mem_req.valid && !mem_req.we && mem_req.addr == $past(gp_source_val))
        else $error("post-increment load address wrong");
    a_predec_addr: assert property (take && op_code[3:0] == fcm_pkg::SUB_PREDEC_STORE
        |=> mem_req.valid && mem_req.we && mem_req.addr == $past(gp_dest_val) - 32'h4)
        else $error("pre-decrement store address wrong");
    a_index_load: assert property (take && op_code[3:0] == fcm_pkg::SUB_IDX_LOAD
        |=> !op_ready && mem_req.addr == $past(gp_index_val) + $past(gp_source_val))
        else $error("indexed load address wrong");
    a_index_store: assert property (take && op_code[3:0] == fcm_pkg::SUB_IDX_STORE
        |=> mem_req.we && mem_req.addr == $past(gp_index_val) + $past(gp_dest_val))
        else $error("indexed store address wrong");
    a_err_no_wb: assert property (mem_req.valid && mem_done && mem_addr_err
        |=> addr_err_evt && !gp_wb.valid && op_ready && !mem_req.valid)
        else $error("address error still wrote back");
    a_postinc_wb: assert property (ok_done && kind_r == fcm_pkg::SUB_POSTINC_LOAD
        |=> gp_wb.valid && gp_wb.data == $past(mem_req.addr) + fcm_pkg::GP_STEP)
        else $error("post-increment writeback wrong");
    a_predec_wb: assert property (ok_done && kind_r == fcm_pkg::SUB_PREDEC_STORE
        |=> gp_wb.valid && gp_wb.data == $past(mem_req.addr) && !addr_err_evt)
        else $error("pre-decrement writeback wrong");
    a_invalid_cause: assert property (invalid_evt
        |-> $past(take) && $past(op_code[3:0]) == fcm_pkg::SUB_MAC)
        else $error("invalid event without an accumulate op");
    c_postinc_ok: cover property (gp_wb.valid && kind_r == fcm_pkg::SUB_POSTINC_LOAD);
    c_store_err: cover property (addr_err_evt && kind_r == fcm_pkg::SUB_PREDEC_STORE);
    c_invalid: cover property (invalid_evt);
endmodule

bind fcm_fpu_slice fcm_fpu_slice_props u_props (.clock(clock), .rst_n(rst_n),
    .op_valid(op_valid), .op_code(op_code), .gp_source_val(gp_source_val),
    .gp_dest_val(gp_dest_val), .gp_index_val(gp_index_val), .mem_done(mem_done),
    .mem_addr_err(mem_addr_err), .op_ready(op_ready), .mem_req(mem_req), .gp_wb(gp_wb),
    .invalid_evt(invalid_evt), .addr_err_evt(addr_err_evt));

// ---- dv/fcm_mem_model.sv ----
`timescale 1ns/1ns
module fcm_mem_model #(
    parameter logic [31:0] RD_MIX = 32'h5A0F3C96
) (
    input wire logic clock,
    input wire logic rst_n,
    input fcm_pkg::fcm_mem_req_t mem_req,
    input wire logic [1:0] lat,
    input wire logic err_in,
    output logic mem_done,
    output logic mem_addr_err,
    output logic [31:0] mem_rdata
);
    logic [1:0] cnt;
    // answers after lat waiting cycles; data and error lines churn outside the done cycle
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 2'h0;
            mem_done <= 1'b0;
            mem_addr_err <= 1'b0;
            mem_rdata <= 32'h0;
        end
        else
        begin
            mem_done <= 1'b0;
            mem_addr_err <= ~mem_addr_err;
            mem_rdata <= ~mem_rdata;
            if (mem_req.valid && !mem_done && cnt == lat)
            begin
                mem_done <= 1'b1;
                mem_addr_err <= err_in;
                mem_rdata <= mem_req.addr ^ RD_MIX;
                cnt <= 2'h0;
            end
            else if (mem_req.valid && !mem_done)
                cnt <= cnt + 2'h1;
        end
    end
endmodule

// ---- dv/fcm_fpu_slice_bench.sv ----
`timescale 1ns/1ns
module fcm_fpu_slice_bench;
    typedef struct {byte k; logic [35:0] v;} fcm_note_t;
    localparam logic [31:0] MIX = 32'h5A0F3C96;
    logic clock = 1'b0, rst_n = 1'b0, op_valid = 1'b0, comm_wr_valid = 1'b0, m_err = 1'b0;
    logic [15:0] op_code = 16'h0;
    logic [31:0] gp_source_val = 32'h0, gp_dest_val = 32'h0, gp_index_val = 32'h0;
    logic [31:0] comm_wr_data = 32'h0, mem_rdata, fp_comm_register, fr_rd_data;
    logic [3:0] fr_rd_sel = 4'h0;
    logic [1:0] m_lat = 2'h0;
    logic op_ready, mem_done, mem_addr_err, invalid_evt, addr_err_evt, vprev;
    fcm_pkg::fcm_mem_req_t mem_req;
    fcm_pkg::fcm_gp_wb_t gp_wb;
    byte pk = 0, pkd;
    fcm_note_t note_q[$];
    int err_total = 0, total_checks = 0;
    logic [31:0] ci[5] = '{32'h3, 32'hFFFFFFFF, 32'h0, 32'h80000000, 32'h01000001};
    logic [31:0] co[5] = '{32'h40400000, 32'hBF800000, 32'h0, 32'hCF000000, 32'h4B800000};
    logic [3:0] fm[6] = '{4'h9, 4'hB, 4'h6, 4'h7, 4'h8, 4'hA};
    always #5 clock = ~clock;
    fcm_fpu_slice uut (.clock(clock), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
        .gp_source_val(gp_source_val), .gp_dest_val(gp_dest_val), .gp_index_val(gp_index_val),
        .comm_wr_valid(comm_wr_valid), .comm_wr_data(comm_wr_data), .mem_done(mem_done),
        .mem_addr_err(mem_addr_err), .mem_rdata(mem_rdata), .fr_rd_sel(fr_rd_sel),
        .op_ready(op_ready), .mem_req(mem_req), .gp_wb(gp_wb), .fp_comm_register(fp_comm_register),
        .fr_rd_data(fr_rd_data), .invalid_evt(invalid_evt), .addr_err_evt(addr_err_evt));
    fcm_mem_model #(.RD_MIX(MIX)) mem (.clock(clock), .rst_n(rst_n), .mem_req(mem_req),
        .lat(m_lat), .err_in(m_err), .mem_done(mem_done), .mem_addr_err(mem_addr_err),
        .mem_rdata(mem_rdata));
    task automatic nt(byte k, logic [35:0] v);
        note_q.push_back('{k, v});
    endtask
    task automatic chk(byte k, logic [35:0] v);
        fcm_note_t h = '{8'h3F, 36'h0};
        total_checks++;
        if (note_q.size() != 0)
            h = note_q.pop_front();
        if (h.k != k || h.v !== v)
        begin
            err_total++;
            $display("Error %c expected %c %h seen %h", k, h.k, h.v, v);
        end
    endtask
    task automatic op(logic [15:0] c);
        @(posedge clock);
        op_valid <= 1'b1;
        op_code <= c;
        @(posedge clock);
        op_valid <= 1'b0;
    endtask
    task automatic peek(logic [3:0] s, byte k, logic [31:0] v);
        nt(k, {4'h0, v});
        @(posedge clock);
        fr_rd_sel <= s;
        pk <= k;
        @(posedge clock);
        pk <= 0;
    endtask
    task automatic put(logic [3:0] n, logic [31:0] v);
        @(posedge clock);
        comm_wr_valid <= 1'b1;
        comm_wr_data <= v;
        @(posedge clock);
        comm_wr_valid <= 1'b0;
        op({4'hF, n, fcm_pkg::SYS_COMM_TO_FR, fcm_pkg::SUB_SYS});
    endtask
    task automatic mop(logic [3:0] f, logic e);
        m_lat <= e ? 2'h3 : 2'h0;
        m_err <= e;
        op({4'hF, 4'h8, 4'h7, f});
        // look after the monitor so that its checks of this edge run first
        repeat (40)
        begin
            @(posedge clock);
            #2;
            if (op_ready === 1'b1)
                break;
        end
        chk("R", {35'h0, op_ready});
    endtask
    task automatic give_verdict();
        err_total += note_q.size();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // every result that shows at the outputs takes the oldest note
    always @(posedge clock)
    begin
        pkd = pk;
        #1;
        if (mem_req.valid && !vprev)
            chk("A", {3'h0, mem_req.we, mem_req.addr});
        if (mem_req.valid && !vprev && mem_req.we)
            chk("S", {4'h0, mem_req.wdata});
        vprev = mem_req.valid;
        if (gp_wb.valid)
            chk("W", {gp_wb.sel, gp_wb.data});
        if (invalid_evt)
            chk("I", 36'h0);
        if (addr_err_evt)
            chk("E", 36'h0);
        if (pkd == "F")
            chk("F", {4'h0, fr_rd_data});
        if (pkd == "C")
            chk("C", {4'h0, fp_comm_register});
    end
    initial
    begin
        #100000;
        err_total++;
        give_verdict();
    end
    initial
    begin
        logic [31:0] s, d, x, v, a, f8;
        logic [3:0] f;
        logic w;
        void'($urandom(32'h726b885f));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        peek(4'h0, "F", 32'h0);
        peek(4'h0, "C", 32'h0);
        $display("test reset done");
        v = $urandom;
        put(4'h7, v);
        peek(4'h7, "F", v);
        put(4'h6, ~v);
        // register move of FR7 into FR9, then FR9 out to the comm register
        op(16'hF97C);
        op({4'hF, 4'h9, fcm_pkg::SYS_FR_TO_COMM, fcm_pkg::SUB_SYS});
        peek(4'h9, "C", v);
        $display("test comm moves done");
        for (int i = 0; i < 5; i++)
        begin
            put(4'h2, ci[i]);
            op({4'hF, 4'h2, fcm_pkg::SYS_INT_CONVERT, fcm_pkg::SUB_SYS});
            peek(4'h2, "F", co[i]);
        end
        $display("test convert done");
        put(4'h0, 32'h40000000);
        put(4'h3, 32'h40800000);
        put(4'h5, 32'h3F800000);
        op(16'hF53E);
        peek(4'h5, "F", 32'h41100000);
        peek(4'h3, "F", 32'h40800000);
        op(16'hF05E);
        peek(4'h0, "F", 32'h41A00000);
        put(4'h1, 32'h00000001);
        put(4'h6, 32'h80400000);
        op(16'hF51E);
        peek(4'h5, "F", 32'h41100000);
        op(16'hF61E);
        peek(4'h6, "F", 32'h00000000);
        put(4'h4, 32'h7F800001);
        nt("I", 36'h0);
        op(16'hF54E);
        peek(4'h5, "F", fcm_pkg::DEFAULT_QNAN);
        $display("test accumulate done");
        f8 = 32'h0;
        for (int i = 0; i < 12; i++)
        begin
            f = fm[i / 2];
            s = $urandom & 32'hFFFFFFFC;
            d = $urandom & 32'hFFFFFFFC;
            x = $urandom & 32'h0000FFFC;
            @(posedge clock);
            gp_source_val <= s;
            gp_dest_val <= d;
            gp_index_val <= x;
            w = (f == 4'hB) || (f == 4'h7) || (f == 4'hA);
            a = (f == 4'h9 || f == 4'h8) ? s : (f == 4'hB) ? d - 32'h4 : (f == 4'hA) ? d
                : (f == 4'h6) ? x + s : x + d;
            nt("A", {3'h0, w, a});
            if (w)
                nt("S", {4'h0, v});
            if (i % 2 == 0)
                nt("E", 36'h0);
            else if (f == 4'h9)
                nt("W", {4'h7, s + 32'h4});
            else if (f == 4'hB)
                nt("W", {4'h8, d - 32'h4});
            nt("R", 36'h1);
            mop(f, i % 2 == 0);
            if (!w && i % 2 == 1)
                f8 = a ^ MIX;
            if (!w)
                peek(4'h8, "F", f8);
        end
        $display("test memory moves done");
        give_verdict();
    end
endmodule
